// ===== mbr_pkg.sv
// package: register map, field layout and codes for the mic bias and input routing bank
package mbr_pkg;
  // page and register numbers
  localparam logic [7:0] MBR_PAGE = 8'h01;
  localparam logic [7:0] MBR_REG_BIAS = 8'h33;
  localparam logic [7:0] MBR_REG_LPOS = 8'h34;
  localparam logic [7:0] MBR_REG_RSVD = 8'h35;
  localparam logic [7:0] MBR_REG_LNEG = 8'h36;
  localparam logic [7:0] MBR_REG_RPOS = 8'h37;
  // page select register, always mapped at word 0
  localparam logic [11:0] MBR_OFF_PAGE = 12'h000;
  // bias field positions
  localparam int MBR_BIAS_PWR_BIT = 6;
  localparam int MBR_BIAS_LVL_LSB = 4;
  localparam int MBR_BIAS_SRC_BIT = 3;
  localparam logic [7:0] MBR_BIAS_WMASK = 8'h78;
  // reset values
  localparam logic [7:0] MBR_RST_BIAS = 8'h00;
  localparam logic [7:0] MBR_RST_ROUTE = 8'h00;
  localparam logic [7:0] MBR_RST_PAGE = 8'h00;
  // bias level codes
  localparam logic [1:0] MBR_LVL_SUPPLY = 2'h3;
  // routing selector codes
  localparam logic [1:0] MBR_RT_OPEN = 2'h0;
  localparam logic [1:0] MBR_RT_10K = 2'h1;
  localparam logic [1:0] MBR_RT_20K = 2'h2;
  localparam logic [1:0] MBR_RT_40K = 2'h3;
  // AXI responses
  localparam logic [1:0] MBR_RESP_OKAY = 2'h0;
  localparam logic [1:0] MBR_RESP_SLVERR = 2'h2;
endpackage : mbr_pkg

// ===== mbr_regs.sv
// mic bias and gain stage input routing register bank, AXI4-Lite slave
`timescale 1ns/1ps
// Functional notes
// - bias bit 6: 0 powers bias generator down, 1 powers it up
// - bias level codes 00,01,10 pick a level; 11 ties bias to supply
// - bias bit 3 selects analog supply (0) or regulator input supply (1)
// - bias bits 7 and 2..0 read zero; software writes only zeros there
// - left positive routing: input_one_left, input_two_left, input_three_left, input_one_right selectors high to low
// - selector codes: 00 open, 01 10k, 10 20k, 11 40k series resistance
// - register 53 is reserved, reads zero; software writes only zero
// - left negative routing: common path first, input_two_right, input_three_right high to low
// - left negative bits 1..0 select second common path, same encoding
// - right positive routing: input_one_right, input_two_right, input_three_right, input_two_left selectors high to low
// - all routing selectors read/write and reset to 00, nothing connected
// - registers decoded on page 1 at numbers 0x33 to 0x37
module mbr_regs
  import mbr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic microphoneBiasPowerUp,
  output logic [3:0] microphoneBiasLevelSel,
  output logic microphoneBiasFromRegulator,
  output logic [3:0] leftGainFromInputOneLeft,
  output logic [3:0] leftGainFromInputTwoLeft,
  output logic [3:0] leftGainFromInputThreeLeft,
  output logic [3:0] leftGainFromInputOneRight,
  output logic [3:0] leftGainFromCommonPathFirst,
  output logic [3:0] leftGainFromInputTwoRight,
  output logic [3:0] leftGainFromInputThreeRight,
  output logic [3:0] leftGainFromCommonPathSecond,
  output logic [3:0] rightGainFromInputOneRight,
  output logic [3:0] rightGainFromInputTwoRight,
  output logic [3:0] rightGainFromInputThreeRight,
  output logic [3:0] rightGainFromInputTwoLeft
);

  // registers
  logic [7:0] pageSel;
  logic [7:0] biasConfiguration;
  logic [7:0] leftGainPositiveRouting;
  logic [7:0] leftGainNegativeRouting;
  logic [7:0] rightGainPositiveRouting;

  // write channel capture
  logic awHeld;
  logic wHeld;
  logic [11:0] awAddr;
  logic [7:0] wByte;
  logic wLane0;
  logic doWrite;

  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHeld <= 1'b0;
      awAddr <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld <= 1'b1;
      awAddr <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wHeld <= 1'b0;
      wByte <= 8'h00;
      wLane0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld <= 1'b1;
      wByte <= s_axi_wdata[7:0];
      wLane0 <= s_axi_wstrb[0];
    end else if (doWrite) begin
      wHeld <= 1'b0;
    end
  end

  // address decode: page select at word 0, bank at 4 times register number
  function automatic logic mbr_hit(input logic [11:0] addr, input logic [7:0] page,
                                   input logic [7:0] num);
    mbr_hit = (page == MBR_PAGE) && (addr[1:0] == 2'h0) && (addr[11:10] == 2'h0)
              && (addr[9:2] == num);
  endfunction : mbr_hit

  function automatic logic mbr_mapped(input logic [11:0] addr, input logic [7:0] page);
    mbr_mapped = (addr == MBR_OFF_PAGE) || mbr_hit(addr, page, MBR_REG_BIAS)
                 || mbr_hit(addr, page, MBR_REG_LPOS) || mbr_hit(addr, page, MBR_REG_RSVD)
                 || mbr_hit(addr, page, MBR_REG_LNEG) || mbr_hit(addr, page, MBR_REG_RPOS);
  endfunction : mbr_mapped

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= MBR_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mbr_mapped(awAddr, pageSel) ? MBR_RESP_OKAY : MBR_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // register stores; byte lane 0 only, upper lanes ignored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pageSel <= MBR_RST_PAGE;
    end else if (doWrite && wLane0 && awAddr == MBR_OFF_PAGE) begin
      pageSel <= wByte;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      biasConfiguration <= MBR_RST_BIAS;
    end else if (doWrite && wLane0 && mbr_hit(awAddr, pageSel, MBR_REG_BIAS)) begin
      // reserved bits forced to zero whatever is written
      biasConfiguration <= wByte & MBR_BIAS_WMASK;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      leftGainPositiveRouting <= MBR_RST_ROUTE;
      leftGainNegativeRouting <= MBR_RST_ROUTE;
      rightGainPositiveRouting <= MBR_RST_ROUTE;
    end else if (doWrite && wLane0) begin
      if (mbr_hit(awAddr, pageSel, MBR_REG_LPOS)) begin
        leftGainPositiveRouting <= wByte;
      end
      if (mbr_hit(awAddr, pageSel, MBR_REG_LNEG)) begin
        leftGainNegativeRouting <= wByte;
      end
      if (mbr_hit(awAddr, pageSel, MBR_REG_RPOS)) begin
        rightGainPositiveRouting <= wByte;
      end
      // register 53 has no storage; writes are accepted and dropped
    end
  end

  // read channel
  logic [7:0] readByte;

  always_comb begin
    readByte = 8'h00;
    if (s_axi_araddr == MBR_OFF_PAGE) begin
      readByte = pageSel;
    end else if (mbr_hit(s_axi_araddr, pageSel, MBR_REG_BIAS)) begin
      readByte = biasConfiguration;
    end else if (mbr_hit(s_axi_araddr, pageSel, MBR_REG_LPOS)) begin
      readByte = leftGainPositiveRouting;
    end else if (mbr_hit(s_axi_araddr, pageSel, MBR_REG_RSVD)) begin
      readByte = 8'h00;
    end else if (mbr_hit(s_axi_araddr, pageSel, MBR_REG_LNEG)) begin
      readByte = leftGainNegativeRouting;
    end else if (mbr_hit(s_axi_araddr, pageSel, MBR_REG_RPOS)) begin
      readByte = rightGainPositiveRouting;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= MBR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, readByte};
      s_axi_rresp <= mbr_mapped(s_axi_araddr, pageSel) ? MBR_RESP_OKAY : MBR_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // one-hot decode of a selector: bit0 open, bit1 10k, bit2 20k, bit3 40k
  function automatic logic [3:0] mbr_route(input logic [1:0] code);
    case (code)
      MBR_RT_OPEN: mbr_route = 4'h1;
      MBR_RT_10K: mbr_route = 4'h2;
      MBR_RT_20K: mbr_route = 4'h4;
      MBR_RT_40K: mbr_route = 4'h8;
      default: mbr_route = 4'h1;
    endcase
  endfunction : mbr_route

  // decoded controls registered off stored bits, one cycle behind the store
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      microphoneBiasPowerUp <= 1'b0;
      microphoneBiasLevelSel <= 4'h1;
      microphoneBiasFromRegulator <= 1'b0;
    end else begin
      microphoneBiasPowerUp <= biasConfiguration[MBR_BIAS_PWR_BIT];
      // bit3 of the level select means bias tied to supply
      microphoneBiasLevelSel <= mbr_route(biasConfiguration[MBR_BIAS_LVL_LSB +: 2]);
      microphoneBiasFromRegulator <= biasConfiguration[MBR_BIAS_SRC_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      leftGainFromInputOneLeft <= 4'h1;
      leftGainFromInputTwoLeft <= 4'h1;
      leftGainFromInputThreeLeft <= 4'h1;
      leftGainFromInputOneRight <= 4'h1;
      leftGainFromCommonPathFirst <= 4'h1;
      leftGainFromInputTwoRight <= 4'h1;
      leftGainFromInputThreeRight <= 4'h1;
      leftGainFromCommonPathSecond <= 4'h1;
      rightGainFromInputOneRight <= 4'h1;
      rightGainFromInputTwoRight <= 4'h1;
      rightGainFromInputThreeRight <= 4'h1;
      rightGainFromInputTwoLeft <= 4'h1;
    end else begin
      leftGainFromInputOneLeft <= mbr_route(leftGainPositiveRouting[7:6]);
      leftGainFromInputTwoLeft <= mbr_route(leftGainPositiveRouting[5:4]);
      leftGainFromInputThreeLeft <= mbr_route(leftGainPositiveRouting[3:2]);
      leftGainFromInputOneRight <= mbr_route(leftGainPositiveRouting[1:0]);
      leftGainFromCommonPathFirst <= mbr_route(leftGainNegativeRouting[7:6]);
      leftGainFromInputTwoRight <= mbr_route(leftGainNegativeRouting[5:4]);
      leftGainFromInputThreeRight <= mbr_route(leftGainNegativeRouting[3:2]);
      leftGainFromCommonPathSecond <= mbr_route(leftGainNegativeRouting[1:0]);
      rightGainFromInputOneRight <= mbr_route(rightGainPositiveRouting[7:6]);
      rightGainFromInputTwoRight <= mbr_route(rightGainPositiveRouting[5:4]);
      rightGainFromInputThreeRight <= mbr_route(rightGainPositiveRouting[3:2]);
      rightGainFromInputTwoLeft <= mbr_route(rightGainPositiveRouting[1:0]);
    end
  end

endmodule : mbr_regs

// ===== mbr_regs_chk.sv
// checker: bus handshake and decoded output properties of the bank
`timescale 1ns/1ps
module mbr_regs_chk
  import mbr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic microphoneBiasPowerUp,
  input wire logic [3:0] microphoneBiasLevelSel,
  input wire logic [3:0] leftGainFromInputOneLeft
);
  logic [11:0] lastAr;
  // address of the read in flight, to judge its data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) lastAr <= 12'h000;
    else if (s_axi_arvalid && s_axi_arready) lastAr <= s_axi_araddr;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_level_one_hot: assert property ($onehot(microphoneBiasLevelSel))
    else $error("bias level select not one-hot");
  a_route_one_hot: assert property ($onehot(leftGainFromInputOneLeft))
    else $error("routing select not one-hot");
  a_bias_rsvd_zero: assert property (s_axi_rvalid && lastAr == 12'h0cc |->
    s_axi_rdata[7] == 1'b0 && s_axi_rdata[2:0] == 3'h0) else $error("bias reserved bits set");
  a_rsvd_reads_zero: assert property (s_axi_rvalid && lastAr == 12'h0d4 |->
    s_axi_rdata == 32'h0) else $error("reserved register not zero");
  a_out_after_write: assert property ($changed(microphoneBiasPowerUp) ||
    $changed(microphoneBiasLevelSel) |-> $past(s_axi_bvalid)) else $error("output moved w/o write");
  a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken with response pending");
endmodule : mbr_regs_chk
bind mbr_regs mbr_regs_chk chk_u (.clk, .rst, .s_axi_awready, .s_axi_wready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_araddr, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata,
  .s_axi_rvalid, .microphoneBiasPowerUp, .microphoneBiasLevelSel, .leftGainFromInputOneLeft);

// ===== tb_mbr_regs.sv
// testbench: register access and decoded outputs of the bank
`timescale 1ns/1ps
module tb_mbr_regs;
  import mbr_pkg::*;
  logic clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pwr, reg_src;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [3:0] s_axi_wstrb, lvl;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  wire [15:0] rt [3];
  logic [7:0] lst [5];
  logic [7:0] d;
  int seed, cyc, miscompares, comparisons;
  mbr_regs dut_u (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .microphoneBiasPowerUp(pwr), .microphoneBiasLevelSel(lvl),
    .microphoneBiasFromRegulator(reg_src), .leftGainFromInputOneLeft(rt[0][15:12]),
    .leftGainFromInputTwoLeft(rt[0][11:8]), .leftGainFromInputThreeLeft(rt[0][7:4]),
    .leftGainFromInputOneRight(rt[0][3:0]), .leftGainFromCommonPathFirst(rt[1][15:12]),
    .leftGainFromInputTwoRight(rt[1][11:8]), .leftGainFromInputThreeRight(rt[1][7:4]),
    .leftGainFromCommonPathSecond(rt[1][3:0]), .rightGainFromInputOneRight(rt[2][15:12]),
    .rightGainFromInputTwoRight(rt[2][11:8]), .rightGainFromInputThreeRight(rt[2][7:4]),
    .rightGainFromInputTwoLeft(rt[2][3:0]));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic complete_run;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  // generous ceiling: the sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  function automatic logic [3:0] dec(input logic [1:0] c);
    return 4'h1 << c;
  endfunction : dec
  function automatic logic [15:0] ex(input logic [7:0] v);
    return {dec(v[7:6]), dec(v[5:4]), dec(v[3:2]), dec(v[1:0])};
  endfunction : ex
  // handshakes judged at the falling edge, released after the rising one
  task automatic wr(input logic [11:0] a, input logic [7:0] v, output logic [1:0] rs);
    logic ta, tw, tb;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid && s_axi_bready;
      rs = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      s_axi_bready <= !tb;
    end
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ta, tb;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge clk);
      ta = s_axi_arvalid && s_axi_arready;
      tb = s_axi_rvalid && s_axi_rready;
      v = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
      s_axi_rready <= !tb;
    end
  endtask : rd
  task automatic wc(input int i, input logic [7:0] v);
    logic [11:0] a;
    logic [7:0] w;
    a = 12'h0cc + 12'(4 * i);
    // software keeps reserved bits and the reserved register at zero
    w = (i == 0) ? (v & MBR_BIAS_WMASK) : ((i == 2) ? 8'h00 : v);
    lst[i] = w;
    wr(a, w, r);
    chk("bresp", 32'(r), 32'(MBR_RESP_OKAY));
    rd(a, q, r);
    chk("rdata", q, {24'h0, lst[i]});
    chk("rresp", 32'(r), 32'(MBR_RESP_OKAY));
    @(negedge clk);
    if (i == 0) begin
      chk("power", 32'(pwr), 32'(lst[0][6]));
      chk("level", 32'(lvl), 32'(dec(lst[0][5:4])));
      chk("source", 32'(reg_src), 32'(lst[0][3]));
    end else if (i != 2) chk("route", 32'(rt[i / 2]), 32'(ex(lst[i])));
    @(posedge clk);
  endtask : wc
  initial begin
    seed = 43388;
    {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    s_axi_wstrb = 4'hf;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("idle", {rt[0], rt[2]}, 32'h11111111);
    chk("idleBias", 32'({pwr, reg_src, lvl, rt[1]}), 32'h00011111);
    @(posedge clk);
    wr(12'h000, 8'h01, r);
    for (int i = 0; i < 5; i++) begin
      rd(12'h0cc + 12'(4 * i), q, r);
      chk("reset", q, 32'h0);
    end
    for (int k = 0; k < 8; k++) begin
      for (int i = 0; i < 5; i++) begin
        d = (k < 2) ? (k ? 8'he4 : 8'h1b) : 8'($random(seed));
        if (i == 0) d[5:4] = 2'(k);
        wc(i, d);
      end
    end
    s_axi_wstrb <= 4'he;
    wr(12'h0d0, ~lst[1], r);
    rd(12'h0d0, q, r);
    chk("strobe", q, {24'h0, lst[1]});
    s_axi_wstrb <= 4'hf;
    wr(12'h000, 8'h00, r);
    wr(12'h0d0, ~lst[1], r);
    chk("pageWr", 32'(r), 32'(MBR_RESP_SLVERR));
    rd(12'h0cc, q, r);
    chk("pageRd", {q[29:0], r}, 32'(MBR_RESP_SLVERR));
    wr(12'h000, 8'h01, r);
    rd(12'h0e0, q, r);
    chk("unmapped", 32'(r), 32'(MBR_RESP_SLVERR));
    rd(12'h0d0, q, r);
    chk("kept", q, {24'h0, lst[1]});
    complete_run();
  end
endmodule : tb_mbr_regs
